// [pds_pkg.sv]
// Shared constants and types for the power-down controller pair.
// Assumes one 20 MHz clock shared by both ends.
package pds_pkg;
  // Power-down select field placement inside the CPU control/status word
  localparam int SEL_LSB = 10;
  localparam int SEL_W = 6;
  // Select field codes
  localparam logic [5:0] SEL_NONE = 6'h00;
  localparam logic [5:0] SEL_GATE_ENABLED = 6'h09;
  localparam logic [5:0] SEL_GATE_ANY = 6'h11;
  localparam logic [5:0] SEL_PLL_OUT = 6'h1a;
  localparam logic [5:0] SEL_PLL_IN = 6'h1c;
  // Reserved top bit of the select field
  localparam int SEL_RSVD_BIT = 5;
  // Cycles from the select write to clock-gating sleep taking hold
  localparam logic [3:0] GATE_DELAY = 4'h8;
  // Clock period and relock figures
  localparam int CLK_NS = 50;
  localparam int LOCK_TYP_US = 75;
  localparam int LOCK_MARGIN_PCT = 150;
  localparam int RELOCK_NS = LOCK_TYP_US * 1000 * (100 + LOCK_MARGIN_PCT) / 100;
  localparam int RELOCK_CYC = (RELOCK_NS + CLK_NS - 1) / CLK_NS;
  localparam int RELOCK_W = 12;
  // Controller register offsets (byte addresses)
  localparam logic [3:0] REG_SELECT = 4'h0;
  localparam logic [3:0] REG_IRQ = 4'h4;
  localparam logic [3:0] REG_RESET = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  // Field positions in the controller's IRQ register
  localparam int IRQ_GLOBAL_BIT = 0;
  localparam int IRQ_NMI_BIT = 1;
  localparam int IRQ_EN_BIT = 2;
  localparam int IRQ_RAISE_BIT = 3;
  // Field positions in the controller's STATUS register
  localparam int ST_STATE_LSB = 6;
  localparam int ST_IND_BIT = 9;
  localparam int ST_BUSY_BIT = 10;
  localparam int ST_ISR_BIT = 11;
  localparam int ST_RES_BIT = 12;
  // Power-down states of the device end
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_ARM = 3'b001,
    ST_GATE = 3'b010,
    ST_PLL_OUT = 3'b011,
    ST_PLL_IN = 3'b100
  } pds_state_t;
endpackage : pds_pkg

// [pds_if.sv]
// Link between the power-down logic and the CPU/interrupt/reset side.
// Both ends share clock_i; every signal is synchronous to it.
`timescale 1ns/1ns
interface pds_if;
  logic sys_reset; // Device reset from the system side
  logic csr_wr; // One-cycle write of the select field
  logic [5:0] csr_wdata; // Select field value
  logic global_irq_enable; // Global interrupt enable level
  logic nonmaskable_irq_enable; // Non-maskable enable level
  logic irq_pend; // Interrupt pending pulse or level
  logic irq_enabled; // Pending interrupt is enabled in irq_enable_reg
  logic cpu_clk_en; // CPU clock not gated
  logic wake_isr; // Pulse: wake into service routine
  logic wake_resume; // Pulse: wake straight to resume point
  logic [5:0] select; // Current power_down_select field
  pds_pkg::pds_state_t state; // Current power-down state
  modport dev (input sys_reset, csr_wr, csr_wdata, global_irq_enable, nonmaskable_irq_enable, irq_pend, irq_enabled,
    output cpu_clk_en, wake_isr, wake_resume, select, state);
  modport sys (output sys_reset, csr_wr, csr_wdata, global_irq_enable, nonmaskable_irq_enable, irq_pend, irq_enabled,
    input cpu_clk_en, wake_isr, wake_resume, select, state);
endinterface : pds_if

// [pds_device.sv]
// Power-down mode logic of the DSP: select field, sleep states, clock gates.
// Assumes the system end keeps the select write whole and the top bit zero.
// Behaviour
// - Six-bit select field chooses mode and wake
// - Software writes the whole field at once
// - Software writes zero to reserved top bit
// - Clock-gating sleep holds eight cycles after write
// - Non-enabled wake resumes without service routine
// - Enabled wake runs service routine then resumes
// - Service routine needs global and non-maskable enables
// - Codes: none, enabled-wake gate, any-wake gate
// - Gate CPU clock only; interrupt and DMA run
// - Code 011010 halts PLL output clock
// - Code 011100 stops PLL input, relock needed
// - PLL sleeps end only by device reset
// - Indicator pin high in both PLL sleeps
// - Registers and outputs hold during PLL sleeps
// - System waits PLL relock after reset
// - Relock wait budgets 150 percent margin
`timescale 1ns/1ns
module pds_device (
  input wire logic clock_i,
  input wire logic rst_i,
  pds_if.dev bus,
  output logic pll_out_en_o,
  output logic pll_in_en_o,
  output logic sleep_indicator_pin_o,
  output logic dma_clk_en_o,
  output logic irq_clk_en_o
);

  // Select field and state registers
  logic [5:0] sel_q;
  pds_pkg::pds_state_t state_q;
  pds_pkg::pds_state_t state_d;
  // Counter for the delay into clock-gating sleep
  logic [3:0] arm_cnt_q;
  // Wake decode
  logic wake_hit;
  logic enabled_only;
  logic do_reset;
  // Output registers
  logic cpu_clk_en_q;
  logic pll_out_en_q;
  logic pll_in_en_q;
  logic ind_q;
  logic wake_isr_q;
  logic wake_res_q;

  // Maps a select code to the state it asks for
  function automatic pds_pkg::pds_state_t code_state(input logic [5:0] code);
    case (code)
      pds_pkg::SEL_GATE_ENABLED: code_state = pds_pkg::ST_ARM;
      pds_pkg::SEL_GATE_ANY: code_state = pds_pkg::ST_ARM;
      pds_pkg::SEL_PLL_OUT: code_state = pds_pkg::ST_PLL_OUT;
      pds_pkg::SEL_PLL_IN: code_state = pds_pkg::ST_PLL_IN;
      default: code_state = pds_pkg::ST_RUN;
    endcase
  endfunction : code_state

  // Either reset source returns the device to run
  assign do_reset = rst_i | bus.sys_reset;

  // Wake qualifier: enabled-only code ignores non-enabled interrupts
  assign enabled_only = (sel_q == pds_pkg::SEL_GATE_ENABLED);
  assign wake_hit = bus.irq_pend & (bus.irq_enabled | ~enabled_only);

  // Next-state decode
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      pds_pkg::ST_RUN: begin
        // Whole field taken from one write
        if (bus.csr_wr) begin
          state_d = code_state(bus.csr_wdata);
        end
      end
      pds_pkg::ST_ARM: begin
        // CPU still runs until the delay expires
        if (arm_cnt_q == pds_pkg::GATE_DELAY - 4'h1) begin
          state_d = pds_pkg::ST_GATE;
        end
      end
      pds_pkg::ST_GATE: begin
        // Any qualifying interrupt ends clock gating
        if (wake_hit) begin
          state_d = pds_pkg::ST_RUN;
        end
      end
      pds_pkg::ST_PLL_OUT: begin
        state_d = pds_pkg::ST_PLL_OUT;
      end
      pds_pkg::ST_PLL_IN: begin
        state_d = pds_pkg::ST_PLL_IN;
      end
      default: begin
        state_d = pds_pkg::ST_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (do_reset) begin
      state_q <= pds_pkg::ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // Select field register
  always_ff @(posedge clock_i) begin
    if (do_reset) begin
      sel_q <= pds_pkg::SEL_NONE;
    end else if (bus.csr_wr && state_q == pds_pkg::ST_RUN) begin
      // Written only in the run state, not while arming
      sel_q <= bus.csr_wdata;
    end else if (state_q == pds_pkg::ST_GATE && wake_hit) begin
      // Field returns to no power-down after a wake
      sel_q <= pds_pkg::SEL_NONE;
    end
  end

  // Delay counter into clock-gating sleep
  always_ff @(posedge clock_i) begin
    if (do_reset || state_q != pds_pkg::ST_ARM) begin
      arm_cnt_q <= 4'h0;
    end else begin
      arm_cnt_q <= arm_cnt_q + 4'h1;
    end
  end

  // Clock gate and indicator outputs follow the next state
  always_ff @(posedge clock_i) begin
    if (do_reset) begin
      cpu_clk_en_q <= 1'b1;
      pll_out_en_q <= 1'b1;
      pll_in_en_q <= 1'b1;
      ind_q <= 1'b0;
    end else begin
      // CPU clock blocked in every sleep state
      cpu_clk_en_q <= (state_d == pds_pkg::ST_RUN) || (state_d == pds_pkg::ST_ARM);
      // PLL output halted in both PLL sleeps
      pll_out_en_q <= (state_d != pds_pkg::ST_PLL_OUT) && (state_d != pds_pkg::ST_PLL_IN);
      // PLL input stopped only in the deepest sleep
      pll_in_en_q <= (state_d != pds_pkg::ST_PLL_IN);
      // Indicator high in both PLL sleeps
      ind_q <= (state_d == pds_pkg::ST_PLL_OUT) || (state_d == pds_pkg::ST_PLL_IN);
    end
  end

  // Wake pulses toward the CPU
  always_ff @(posedge clock_i) begin
    if (do_reset) begin
      wake_isr_q <= 1'b0;
      wake_res_q <= 1'b0;
    end else if (state_q == pds_pkg::ST_GATE && wake_hit) begin
      // Service routine only with both enables and an enabled source
      wake_isr_q <= bus.irq_enabled & bus.global_irq_enable & bus.nonmaskable_irq_enable;
      wake_res_q <= ~(bus.irq_enabled & bus.global_irq_enable & bus.nonmaskable_irq_enable);
    end else begin
      wake_isr_q <= 1'b0;
      wake_res_q <= 1'b0;
    end
  end

  // Link outputs
  assign bus.cpu_clk_en = cpu_clk_en_q;
  assign bus.wake_isr = wake_isr_q;
  assign bus.wake_resume = wake_res_q;
  assign bus.select = sel_q;
  assign bus.state = state_q;
  // Pins; registers and RAM hold because nothing else is clocked here
  assign pll_out_en_o = pll_out_en_q;
  assign pll_in_en_o = pll_in_en_q;
  assign sleep_indicator_pin_o = ind_q;
  // DMA and interrupt logic keep their clock in clock-gating sleep
  assign dma_clk_en_o = pll_out_en_q;
  assign irq_clk_en_o = pll_out_en_q;

endmodule : pds_device

// [pds_system.sv]
// System end: CPU-side register port, interrupt levels, reset and relock wait.
// Assumes a plain strobe master; read data stands one cycle after the strobe.
`timescale 1ns/1ns
module pds_system #(
  parameter int RELOCK_CYCLES = pds_pkg::RELOCK_CYC
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic ready_o,
  pds_if.sys bus
);

  // Interrupt control levels and pulse
  logic glob_en_q;
  logic nmi_en_q;
  logic irq_en_q;
  logic irq_raise_q;
  // Select write toward the device
  logic csr_wr_q;
  logic [5:0] csr_data_q;
  // Reset pulse and relock wait
  logic sys_rst_q;
  logic [pds_pkg::RELOCK_W-1:0] relock_q;
  logic [31:0] rdata_q;
  // Sticky wake indications
  logic seen_isr_q;
  logic seen_res_q;

  // Register writes
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      glob_en_q <= 1'b0;
      nmi_en_q <= 1'b0;
      irq_en_q <= 1'b0;
      irq_raise_q <= 1'b0;
      csr_wr_q <= 1'b0;
      csr_data_q <= pds_pkg::SEL_NONE;
      sys_rst_q <= 1'b0;
    end else begin
      irq_raise_q <= wr_i && addr_i == pds_pkg::REG_IRQ && wdata_i[pds_pkg::IRQ_RAISE_BIT];
      sys_rst_q <= wr_i && addr_i == pds_pkg::REG_RESET && wdata_i[0];
      // Select written as one whole field, top bit forced low; refused during relock
      csr_wr_q <= wr_i && addr_i == pds_pkg::REG_SELECT && relock_q == '0;
      if (wr_i && addr_i == pds_pkg::REG_SELECT) begin
        csr_data_q <= {1'b0, wdata_i[pds_pkg::SEL_RSVD_BIT-1:0]};
      end
      if (wr_i && addr_i == pds_pkg::REG_IRQ) begin
        glob_en_q <= wdata_i[pds_pkg::IRQ_GLOBAL_BIT];
        nmi_en_q <= wdata_i[pds_pkg::IRQ_NMI_BIT];
        irq_en_q <= wdata_i[pds_pkg::IRQ_EN_BIT];
      end
    end
  end

  // Relock wait after a reset that ends the deepest sleep
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      relock_q <= '0;
    end else if (sys_rst_q && bus.state == pds_pkg::ST_PLL_IN) begin
      relock_q <= RELOCK_CYCLES[pds_pkg::RELOCK_W-1:0];
    end else if (relock_q != '0) begin
      relock_q <= relock_q - 1'b1;
    end
  end

  // Sticky wake flags; a new pulse wins over the read clear
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      seen_isr_q <= 1'b0;
      seen_res_q <= 1'b0;
    end else begin
      seen_isr_q <= bus.wake_isr | (seen_isr_q & ~(rd_i && addr_i == pds_pkg::REG_STATUS));
      seen_res_q <= bus.wake_resume | (seen_res_q & ~(rd_i && addr_i == pds_pkg::REG_STATUS));
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clock_i) begin
    if (rst_i || !rd_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      unique case (addr_i)
        pds_pkg::REG_SELECT: rdata_q <= {26'h000_0000, bus.select};
        pds_pkg::REG_IRQ: rdata_q <= {29'h0000_0000, irq_en_q, nmi_en_q, glob_en_q};
        pds_pkg::REG_STATUS: begin
          rdata_q <= 32'h0000_0000;
          rdata_q[pds_pkg::SEL_W-1:0] <= bus.select;
          rdata_q[pds_pkg::ST_STATE_LSB +: 3] <= bus.state;
          rdata_q[pds_pkg::ST_IND_BIT] <= ~bus.cpu_clk_en;
          rdata_q[pds_pkg::ST_BUSY_BIT] <= relock_q != '0;
          rdata_q[pds_pkg::ST_ISR_BIT] <= seen_isr_q;
          rdata_q[pds_pkg::ST_RES_BIT] <= seen_res_q;
        end
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign rdata_o = rdata_q;
  assign ready_o = (relock_q == '0);
  assign bus.sys_reset = sys_rst_q;
  assign bus.csr_wr = csr_wr_q;
  assign bus.csr_wdata = csr_data_q;
  assign bus.global_irq_enable = glob_en_q;
  assign bus.nonmaskable_irq_enable = nmi_en_q;
  assign bus.irq_pend = irq_raise_q;
  assign bus.irq_enabled = irq_en_q;

endmodule : pds_system

// [pds_chk.sv]
// Checker for the power-down link between device and system ends.
// Assumes one clock; the testbench wires it beside the interface.
`timescale 1ns/1ns
module pds_chk (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic sys_reset,
  input wire logic csr_wr,
  input wire logic [5:0] csr_wdata,
  input wire logic global_irq_enable,
  input wire logic nonmaskable_irq_enable,
  input wire logic irq_pend,
  input wire logic irq_enabled,
  input wire logic cpu_clk_en,
  input wire logic wake_isr,
  input wire logic wake_resume,
  input wire logic [5:0] select,
  input wire pds_pkg::pds_state_t state,
  input wire logic sleep_indicator_pin_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  logic take_w; // Select write the device will take
  logic full_w; // Service routine allowed
  logic gwake_w; // Interrupt while gated
  logic run_w; // Running state
  logic pll_w; // Either PLL sleep
  assign take_w = csr_wr && state == pds_pkg::ST_RUN;
  assign full_w = irq_enabled && global_irq_enable && nonmaskable_irq_enable;
  assign gwake_w = state == pds_pkg::ST_GATE && irq_pend;
  assign run_w = state == pds_pkg::ST_RUN;
  assign pll_w = state == pds_pkg::ST_PLL_OUT || state == pds_pkg::ST_PLL_IN;
  // Arming stretch with CPU clock still running
  sequence arm_s;
    (state == pds_pkg::ST_ARM && cpu_clk_en) [*8];
  endsequence
  // Gated state with CPU clock blocked
  sequence gate_s;
    state == pds_pkg::ST_GATE && !cpu_clk_en;
  endsequence
  gate_delay_a: assert property (take_w && csr_wdata inside {6'h09, 6'h11} |=> arm_s ##1 gate_s)
    else $error("clock gate delay wrong");
  pll_out_a: assert property (take_w && csr_wdata == 6'h1a |=> state == pds_pkg::ST_PLL_OUT)
    else $error("output halt not entered");
  pll_in_a: assert property (take_w && csr_wdata == 6'h1c |=> state == pds_pkg::ST_PLL_IN)
    else $error("input stop not entered");
  pll_hold_a: assert property (pll_w && !sys_reset |=> $stable(state) && $stable(select))
    else $error("PLL sleep left without reset");
  reset_exit_a: assert property (sys_reset |=> run_w && select == 6'h00 && cpu_clk_en)
    else $error("device reset did not clear");
  wake_isr_a: assert property (gwake_w && full_w |=> wake_isr && !wake_resume && run_w && cpu_clk_en)
    else $error("enabled wake wrong");
  wake_res_a: assert property (gwake_w && !full_w && (irq_enabled || select == 6'h11)
    |=> wake_resume && !wake_isr && run_w)
    else $error("resume wake wrong");
  no_wake_a: assert property (gwake_w && !irq_enabled && select == 6'h09 |=> gate_s ##0 !wake_resume)
    else $error("woken by non-enabled interrupt");
  reserved_a: assert property (take_w && !(csr_wdata inside {6'h09, 6'h11, 6'h1a, 6'h1c})
    |=> run_w && cpu_clk_en && select == $past(csr_wdata))
    else $error("reserved code slept");
  indicator_a: assert property (sleep_indicator_pin_o == pll_w)
    else $error("indicator pin wrong");
endmodule : pds_chk

// [testbench.sv]
// Self-checking bench for the power-down device and system ends.
// Assumes both ends joined by pds_if on one 20 MHz clock.
`timescale 1ns/1ns
module testbench;
  logic clock_i, rst_i, wr_i, rd_i, ready_o; // Port signals
  logic [3:0] addr_i;
  logic [31:0] wdata_i, rdata_o, rd_q; // rd_q holds last read
  wire logic [4:0] pins_w; // Indicator, PLL out, PLL in, DMA, IRQ enables
  int mismatches, check_count;
  int cycles = 0; // Timeout counter
  typedef struct {logic [5:0] code; logic [8:0] st; logic [4:0] pins;} pds_row_t;
  // Code written, expected state and select, expected pins
  pds_row_t rows [6] = '{'{6'h00, {pds_pkg::ST_RUN, 6'h00}, 5'h0f}, '{6'h01, {pds_pkg::ST_RUN, 6'h01}, 5'h0f},
    '{6'h3f, {pds_pkg::ST_RUN, 6'h1f}, 5'h0f}, '{6'h1b, {pds_pkg::ST_RUN, 6'h1b}, 5'h0f},
    '{6'h1a, {pds_pkg::ST_PLL_OUT, 6'h1a}, 5'h14}, '{6'h1c, {pds_pkg::ST_PLL_IN, 6'h1c}, 5'h10}};
  pds_if link ();
  pds_device pds_device_inst (.clock_i(clock_i), .rst_i(rst_i), .bus(link), .pll_out_en_o(pins_w[3]),
    .pll_in_en_o(pins_w[2]), .sleep_indicator_pin_o(pins_w[4]), .dma_clk_en_o(pins_w[1]), .irq_clk_en_o(pins_w[0]));
  pds_system #(.RELOCK_CYCLES(8)) pds_system_inst (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ready_o(ready_o), .bus(link));
  pds_chk pds_chk_inst (.clock_i(clock_i), .rst_i(rst_i), .sys_reset(link.sys_reset), .csr_wr(link.csr_wr),
    .csr_wdata(link.csr_wdata), .global_irq_enable(link.global_irq_enable),
    .nonmaskable_irq_enable(link.nonmaskable_irq_enable), .irq_pend(link.irq_pend),
    .irq_enabled(link.irq_enabled), .cpu_clk_en(link.cpu_clk_en), .wake_isr(link.wake_isr),
    .wake_resume(link.wake_resume), .select(link.select), .state(link.state), .sleep_indicator_pin_o(pins_w[4]));
  // Clock at 50 ns period
  initial begin
    clock_i = 1'h0;
    forever #25 clock_i = ~clock_i;
  end
  // Hang guard
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  // Compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= {16'h0000, d};
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask : wr
  // One-cycle read; data taken the cycle after
  task automatic rd(input logic [3:0] a);
    @(posedge clock_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'h0;
    #1 rd_q = rdata_o;
  endtask : rd
  // Status state and select field
  task automatic stat(input logic [8:0] exp, input string what);
    rd(4'hc);
    chk(what, {23'h00_0000, exp}, {23'h00_0000, rd_q[8:0]});
  endtask : stat
  // Bounded wait for relock to end
  task automatic wait_ready();
    int n;
    n = 0;
    // Relock count starts two edges after the reset write
    repeat (2) @(posedge clock_i);
    while (ready_o !== 1'h1 && n < 40) begin
      @(posedge clock_i);
      n++;
    end
    chk("ready", 32'h0000_0001, {31'h0000_0000, ready_o});
  endtask : wait_ready
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  // Main sequence
  initial begin
    rst_i = 1'h1;
    wr_i = 1'h0;
    rd_i = 1'h0;
    addr_i = 4'h0;
    wdata_i = 32'h0000_0000;
    mismatches = 0;
    check_count = 0;
    repeat (20) @(posedge clock_i);
    rst_i <= 1'h0;
    rd(4'hc);
    chk("reset status", 32'h0000_0000, rd_q);
    // Each code, an interrupt, then device reset
    foreach (rows[i]) begin
      wr(4'h0, {10'h000, rows[i].code});
      wr(4'h4, 16'h000f);
      stat(rows[i].st, "mode");
      chk("pins", {27'h000_0000, rows[i].pins}, {27'h000_0000, pins_w});
      wr(4'h8, 16'h0001);
      wait_ready();
      stat({pds_pkg::ST_RUN, 6'h00}, "after reset");
    end
    // Enabled wake into service routine
    wr(4'h4, 16'h0007);
    wr(4'h0, 16'h0009);
    stat({pds_pkg::ST_ARM, 6'h09}, "arming");
    repeat (10) @(posedge clock_i);
    stat({pds_pkg::ST_GATE, 6'h09}, "gated");
    chk("gate pins", 32'h0000_000f, {27'h000_0000, pins_w});
    chk("cpu gated", 32'h0000_0200, rd_q & 32'h0000_0200);
    wr(4'h4, 16'h000f);
    @(posedge clock_i); // Sticky flag lands a cycle after the pulse
    rd(4'hc);
    chk("isr wake", 32'h0000_0800, rd_q & 32'h0000_19ff);
    // Non-enabled ignored, then enabled without service routine
    wr(4'h4, 16'h0000);
    wr(4'h0, 16'h0009);
    repeat (12) @(posedge clock_i);
    wr(4'h4, 16'h0008);
    stat({pds_pkg::ST_GATE, 6'h09}, "still gated");
    wr(4'h4, 16'h000c);
    @(posedge clock_i); // Sticky flag lands a cycle after the pulse
    rd(4'hc);
    chk("resume wake", 32'h0000_1000, rd_q & 32'h0000_19ff);
    // Any-interrupt wake
    wr(4'h0, 16'h0011);
    repeat (12) @(posedge clock_i);
    wr(4'h4, 16'h000b);
    @(posedge clock_i); // Sticky flag lands a cycle after the pulse
    rd(4'hc);
    chk("any wake", 32'h0000_1000, rd_q & 32'h0000_19ff);
    // Select refused during relock; only the deepest sleep starts one
    wr(4'h0, 16'h001c);
    wr(4'h8, 16'h0001);
    rd(4'hc);
    chk("busy", 32'h0000_0400, rd_q & 32'h0000_0400);
    wr(4'h0, 16'h001a);
    wait_ready();
    stat({pds_pkg::ST_RUN, 6'h00}, "refused");
    // Unmapped place
    wr(4'h2, 16'h0019);
    rd(4'h2);
    chk("unmapped", 32'h0000_0000, rd_q);
    finish_test();
  end
endmodule : testbench
